// file: logic/dsq_pkg.sv
// Shared constants and types for the DAC refresh sequencer with serial load
package dsq_pkg;

  // Serial word layout, most significant bit first
  localparam int unsigned WORD_BITS     = 24;
  localparam int unsigned CODE_BITS     = 16;
  localparam int unsigned ADDR_BITS     = 5;
  localparam int unsigned CODE_MSB      = 23;
  localparam int unsigned CODE_LSB      = 8;
  localparam int unsigned ADDR_MSB      = 7;
  localparam int unsigned ADDR_LSB      = 3;
  localparam int unsigned MODE_BIT_POS  = 2;
  localparam int unsigned CLKSRC_BIT_POS = 1;
  localparam logic [4:0]  LAST_BIT_IDX  = 5'h17;

  // Channel store
  localparam int unsigned CHANNELS      = 32;
  localparam logic [4:0]  LAST_CHANNEL  = 5'h1F;
  localparam logic [4:0]  FIRST_CHANNEL = 5'h00;
  localparam logic [15:0] ZERO_VOLT_CODE = 16'h4F2C;

  // Sequencer timing
  localparam int unsigned SYS_CLK_NS     = 10;
  localparam int unsigned CHAN_PERIOD_NS = 10000;
  localparam int unsigned OSC_CYCLES     = CHAN_PERIOD_NS / SYS_CLK_NS;
  localparam logic [9:0]  OSC_LAST       = 10'(OSC_CYCLES - 1);
  localparam logic [1:0]  EXTERNAL_SEQUENCER_CLOCK_DIV_LAST  = 2'h3;

  // Synchroniser lanes: toggle, reset pin, clock pin, immediate pin, chip select
  localparam int unsigned SYNC_CS    = 0;
  localparam int unsigned SYNC_IMM   = 1;
  localparam int unsigned SYNC_CLK   = 2;
  localparam int unsigned SYNC_RST   = 3;
  localparam int unsigned SYNC_TOG   = 4;
  localparam logic [4:0]  SYNC_RESET = 5'h09;

  typedef enum logic [3:0] {
    ST_RESET_LOAD = 4'h1,
    ST_RUN        = 4'h2,
    ST_PAUSE      = 4'h4,
    ST_IMM_UPDATE = 4'h8
  } dsq_state_t;

endpackage

// file: logic/dsq_word_if.sv
// Carrier for a received serial word from the link domain to the sequencer
`timescale 1ns/100ps
interface dsq_word_if;
  logic [23:0] word;
  logic        word_toggle;

  modport rx  (output word, output word_toggle);
  modport seq (input word, input word_toggle);
endinterface

// file: logic/dsq_serial_rx.sv
// Serial shift receiver on the link clock; hands each complete word over by toggle
`timescale 1ns/100ps
module dsq_serial_rx (
  input  wire logic  serial_clk,
  input  wire logic  resetn,
  input  wire logic  cs_n,
  input  wire logic  serial_data,
  dsq_word_if.rx     word_out
);

  typedef struct packed {
    logic [22:0] shift;
    logic [23:0] word;
    logic        toggle;
  } dsq_rx_state_t;

  dsq_rx_state_t s_reg;
  dsq_rx_state_t s_next;
  logic [4:0]    bit_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // The link clock stops between frames, so the bit count is cleared by the
  // frame signal itself rather than by any edge after the frame.
  always_ff @(posedge serial_clk or negedge resetn or posedge cs_n) begin
    if (!resetn || cs_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (bit_cnt_reg == dsq_pkg::LAST_BIT_IDX) begin
      bit_cnt_reg <= 5'h00;
    end else begin
      bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
    end
  end

  always_comb begin
    s_next       = s_reg;
    s_next.shift = {s_reg.shift[21:0], serial_data};
    if (bit_cnt_reg == dsq_pkg::LAST_BIT_IDX) begin
      s_next.word   = {s_reg.shift, serial_data};
      s_next.toggle = ~s_reg.toggle;
    end
  end

  always_ff @(posedge serial_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Word stays stable for a whole following word, far longer than the crossing
  assign word_out.word        = s_reg.word;
  assign word_out.word_toggle = s_reg.toggle;

endmodule

// file: logic/dsq_external_sequencer_clock_div.sv
// External sequencer clock synchroniser and divide-by-four tick generator
`timescale 1ns/100ps
module dsq_external_sequencer_clock_div (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic external_sequencer_clock,
  output logic      seq_tick
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [1:0] edge_cnt;
    logic       tick;
  } dsq_div_state_t;

  dsq_div_state_t s_reg;
  dsq_div_state_t s_next;

  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = external_sequencer_clock;
    s_next.sync2 = s_reg.sync1;
    s_next.prev  = s_reg.sync2;
    s_next.tick  = 1'b0;
    if (s_reg.sync2 && !s_reg.prev) begin
      if (s_reg.edge_cnt == dsq_pkg::EXTERNAL_SEQUENCER_CLOCK_DIV_LAST) begin
        s_next.edge_cnt = 2'h0;
        s_next.tick     = 1'b1;
      end else begin
        s_next.edge_cnt = 2'(s_reg.edge_cnt + 2'h1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign seq_tick = s_reg.tick;

endmodule

// file: logic/dsq_top.sv
// Refresh sequencer for a 32-channel sample-and-hold DAC with serial code load
`timescale 1ns/100ps
module dsq_top (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        serial_clk,
  input  wire logic        cs_n,
  input  wire logic        serial_data,
  input  wire logic        immediate_pin,
  input  wire logic        clock_source_pin,
  input  wire logic        external_sequencer_clock,
  input  wire logic        reset_pin_n,
  output logic [15:0]      dac_code,
  output logic             dac_load,
  output logic             hold_strobe,
  output logic [4:0]       hold_channel,
  output logic             oscillator_enable,
  output logic             reset_load_active,
  output logic             sequencer_paused,
  output logic             update_mode_bit,
  output logic             clock_source_bit,
  output logic             external_clock_active
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [4:0]          sync1;
    logic [4:0]          sync2;
    logic                tog_seen;
    logic [9:0]          osc_cnt;
    dsq_pkg::dsq_state_t state;
    logic [4:0]          chan;
    logic                step_done;
    logic                imm_pend;
    logic [4:0]          imm_chan;
    logic                mode_bit;
    logic                clk_bit;
    logic [15:0]         dac_code;
    logic                dac_load;
    logic                hold_strobe;
    logic [4:0]          hold_channel;
    logic                osc_en;
    logic                reset_active;
    logic                paused;
    logic                ext_active;
  } dsq_top_state_t;

  localparam dsq_top_state_t RESET_STATE = '{
    sync1:        dsq_pkg::SYNC_RESET,
    sync2:        dsq_pkg::SYNC_RESET,
    tog_seen:     1'b0,
    osc_cnt:      10'h000,
    state:        dsq_pkg::ST_RESET_LOAD,
    chan:         dsq_pkg::FIRST_CHANNEL,
    step_done:    1'b0,
    imm_pend:     1'b0,
    imm_chan:     dsq_pkg::FIRST_CHANNEL,
    mode_bit:     1'b0,
    clk_bit:      1'b0,
    dac_code:     dsq_pkg::ZERO_VOLT_CODE,
    dac_load:     1'b0,
    hold_strobe:  1'b0,
    hold_channel: dsq_pkg::FIRST_CHANNEL,
    osc_en:       1'b1,
    reset_active: 1'b1,
    paused:       1'b0,
    ext_active:   1'b0
  };

  dsq_top_state_t s_reg;
  dsq_top_state_t s_next;

  logic [15:0] code_mem [0:dsq_pkg::CHANNELS-1];
  logic        mem_we;
  logic [4:0]  mem_addr;
  logic [15:0] mem_data;

  logic        external_sequencer_clock_tick;
  dsq_word_if  word_link ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [4:0] next_chan(input logic [4:0] c);
    if (c == dsq_pkg::LAST_CHANNEL) begin
      next_chan = dsq_pkg::FIRST_CHANNEL;
    end else begin
      next_chan = 5'(c + 5'h01);
    end
  endfunction

  function automatic logic [4:0] word_addr(input logic [23:0] w);
    word_addr = w[dsq_pkg::ADDR_MSB:dsq_pkg::ADDR_LSB];
  endfunction

  function automatic logic [15:0] word_code(input logic [23:0] w);
    word_code = w[dsq_pkg::CODE_MSB:dsq_pkg::CODE_LSB];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  dsq_serial_rx u_rx (
    .serial_clk  (serial_clk),
    .resetn      (resetn),
    .cs_n        (cs_n),
    .serial_data (serial_data),
    .word_out    (word_link.rx)
  );

  dsq_external_sequencer_clock_div u_div (
    .sys_clk                  (sys_clk),
    .resetn                   (resetn),
    .external_sequencer_clock (external_sequencer_clock),
    .seq_tick                 (external_sequencer_clock_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    logic        cs_low;
    logic        imm_eff;
    logic        pin_clk;
    logic        rst_low;
    logic        word_new;
    logic        osc_tick;
    logic        ext_sel;
    logic        tick;
    logic [23:0] w;

    cs_low   = ~s_reg.sync2[dsq_pkg::SYNC_CS];
    imm_eff  = s_reg.sync2[dsq_pkg::SYNC_IMM] | s_reg.mode_bit;
    pin_clk  = s_reg.sync2[dsq_pkg::SYNC_CLK];
    rst_low  = ~s_reg.sync2[dsq_pkg::SYNC_RST];
    word_new = s_reg.sync2[dsq_pkg::SYNC_TOG] ^ s_reg.tog_seen;
    w        = word_link.word;

    s_next             = s_reg;
    s_next.sync1       = {word_link.word_toggle, reset_pin_n, clock_source_pin,
                          immediate_pin, cs_n};
    s_next.sync2       = s_reg.sync1;
    s_next.tog_seen    = s_reg.sync2[dsq_pkg::SYNC_TOG];
    s_next.dac_load    = 1'b0;
    s_next.hold_strobe = 1'b0;
    mem_we             = 1'b0;
    mem_addr           = s_reg.chan;
    mem_data           = dsq_pkg::ZERO_VOLT_CODE;

    // Internal oscillator: forced on during the reset load
    s_next.osc_en = (s_reg.state == dsq_pkg::ST_RESET_LOAD) || !pin_clk;
    osc_tick      = 1'b0;
    if (!s_reg.osc_en) begin
      s_next.osc_cnt = 10'h000;
    end else if (s_reg.osc_cnt == dsq_pkg::OSC_LAST) begin
      s_next.osc_cnt = 10'h000;
      osc_tick       = 1'b1;
    end else begin
      s_next.osc_cnt = 10'(s_reg.osc_cnt + 10'h001);
    end

    ext_sel = (pin_clk | s_reg.clk_bit) &&
              (s_reg.state != dsq_pkg::ST_RESET_LOAD);
    tick    = ext_sel ? external_sequencer_clock_tick : osc_tick;

    // Received words are dropped while the reset load runs
    if (word_new && (s_reg.state != dsq_pkg::ST_RESET_LOAD) && !rst_low) begin
      mem_we          = 1'b1;
      mem_addr        = word_addr(w);
      mem_data        = word_code(w);
      s_next.mode_bit = w[dsq_pkg::MODE_BIT_POS];
      s_next.clk_bit  = w[dsq_pkg::CLKSRC_BIT_POS];
      s_next.imm_chan = word_addr(w);
      s_next.imm_pend = w[dsq_pkg::MODE_BIT_POS] |
                        s_reg.sync2[dsq_pkg::SYNC_IMM];
    end

    case (s_reg.state)
      dsq_pkg::ST_RESET_LOAD: begin
        s_next.dac_code = dsq_pkg::ZERO_VOLT_CODE;
        if (tick) begin
          mem_we              = 1'b1;
          mem_addr            = s_reg.chan;
          mem_data            = dsq_pkg::ZERO_VOLT_CODE;
          s_next.hold_strobe  = 1'b1;
          s_next.hold_channel = s_reg.chan;
          s_next.chan         = next_chan(s_reg.chan);
          s_next.dac_load     = 1'b1;
          if (s_reg.chan == dsq_pkg::LAST_CHANNEL) begin
            s_next.state    = dsq_pkg::ST_RUN;
            s_next.dac_code = code_mem[dsq_pkg::FIRST_CHANNEL];
          end
        end
      end
      dsq_pkg::ST_RUN: begin
        if (tick) begin
          s_next.hold_strobe  = 1'b1;
          s_next.hold_channel = s_reg.chan;
        end
        if (cs_low) begin
          // The step in progress still completes on the coming period end
          s_next.state     = dsq_pkg::ST_PAUSE;
          s_next.step_done = tick;
        end else if (tick) begin
          s_next.chan     = next_chan(s_reg.chan);
          s_next.dac_code = code_mem[next_chan(s_reg.chan)];
          s_next.dac_load = 1'b1;
        end
      end
      dsq_pkg::ST_PAUSE: begin
        if (tick && !s_reg.step_done) begin
          s_next.hold_strobe  = 1'b1;
          s_next.hold_channel = s_reg.chan;
          s_next.step_done    = 1'b1;
        end
        // Resume only on a period boundary after chip select has risen
        if (tick && !cs_low) begin
          s_next.dac_load = 1'b1;
          if (s_reg.imm_pend || (imm_eff && mem_we)) begin
            s_next.state    = dsq_pkg::ST_IMM_UPDATE;
            s_next.dac_code = code_mem[s_reg.imm_chan];
            s_next.imm_pend = 1'b0;
          end else begin
            s_next.state    = dsq_pkg::ST_RUN;
            s_next.dac_code = code_mem[s_reg.chan];
          end
        end
      end
      dsq_pkg::ST_IMM_UPDATE: begin
        if (tick) begin
          s_next.hold_strobe  = 1'b1;
          s_next.hold_channel = s_reg.imm_chan;
          if (cs_low) begin
            s_next.state     = dsq_pkg::ST_PAUSE;
            s_next.step_done = 1'b1;
          end else begin
            s_next.state    = dsq_pkg::ST_RUN;
            s_next.dac_code = code_mem[s_reg.chan];
            s_next.dac_load = 1'b1;
          end
        end
      end
      default: begin
        s_next.state = dsq_pkg::ST_RESET_LOAD;
      end
    endcase

    // Reset pin restarts the zero-volt load from channel 0 while held
    if (rst_low) begin
      s_next.state     = dsq_pkg::ST_RESET_LOAD;
      s_next.chan      = dsq_pkg::FIRST_CHANNEL;
      s_next.osc_cnt   = 10'h000;
      s_next.osc_en    = 1'b1;
      s_next.imm_pend  = 1'b0;
      s_next.mode_bit  = 1'b0;
      s_next.clk_bit   = 1'b0;
      s_next.step_done = 1'b0;
      s_next.dac_code  = dsq_pkg::ZERO_VOLT_CODE;
      s_next.dac_load  = (s_reg.state != dsq_pkg::ST_RESET_LOAD);
    end

    s_next.reset_active = (s_next.state == dsq_pkg::ST_RESET_LOAD);
    s_next.paused       = (s_next.state == dsq_pkg::ST_PAUSE);
    s_next.ext_active   = (pin_clk | s_next.clk_bit) &&
                          (s_next.state != dsq_pkg::ST_RESET_LOAD);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Store has no reset; the reset load overwrites every word before use
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      code_mem[mem_addr] <= mem_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dac_code              = s_reg.dac_code;
  assign dac_load              = s_reg.dac_load;
  assign hold_strobe           = s_reg.hold_strobe;
  assign hold_channel          = s_reg.hold_channel;
  assign oscillator_enable     = s_reg.osc_en;
  assign reset_load_active     = s_reg.reset_active;
  assign sequencer_paused      = s_reg.paused;
  assign update_mode_bit       = s_reg.mode_bit;
  assign clock_source_bit      = s_reg.clk_bit;
  assign external_clock_active = s_reg.ext_active;

endmodule

// file: verification/dsq_assertions.sv
// Port-level assertions for the refresh sequencer top
`timescale 1ns/100ps
module dsq_assertions (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        cs_n,
  input wire logic        clock_source_pin,
  input wire logic [15:0] dac_code,
  input wire logic        dac_load,
  input wire logic        hold_strobe,
  input wire logic [4:0]  hold_channel,
  input wire logic        oscillator_enable,
  input wire logic        reset_load_active,
  input wire logic        sequencer_paused,
  input wire logic        update_mode_bit,
  input wire logic        clock_source_bit,
  input wire logic        external_clock_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  logic [9:0] gap_reg;
  logic [4:0] last_ch_reg;
  // Gap is only meaningful inside the load, where steps never pause
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg     <= 10'h000;
      last_ch_reg <= 5'h1F;
    end else begin
      gap_reg <= hold_strobe ? 10'h000 : gap_reg + 10'h001;
      if (hold_strobe) begin
        last_ch_reg <= hold_channel;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_pulse;
    hold_strobe |=> !hold_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_gap;
    reset_load_active && hold_strobe && hold_channel != 5'h00 |-> gap_reg == 10'h3E7;
  endproperty
  a_gap: assert property (p_gap) else $error("bad internal period");
  property p_wrap;
    reset_load_active && hold_strobe && last_ch_reg == 5'h1F |-> hold_channel == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to channel 0");
  property p_end;
    $fell(reset_load_active) |-> hold_channel == 5'h1F;
  endproperty
  a_end: assert property (p_end) else $error("load ended early");
  property p_code;
    hold_strobe && reset_load_active && $past(reset_load_active) |->
      $past(dac_code) == dsq_pkg::ZERO_VOLT_CODE;
  endproperty
  a_code: assert property (p_code) else $error("load code wrong");
  property p_paused;
    $fell(cs_n) && !reset_load_active |-> ##[1:5] sequencer_paused;
  endproperty
  a_paused: assert property (p_paused) else $error("no pause");
  property p_quiet;
    reset_load_active && $past(reset_load_active, 3) |->
      $stable(update_mode_bit) && $stable(clock_source_bit);
  endproperty
  a_quiet: assert property (p_quiet) else $error("word taken in load");
  property p_osc;
    (clock_source_pin && !reset_load_active) [*6] |-> !oscillator_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator still on");
  property p_ext;
    (clock_source_pin && !reset_load_active) [*6] |-> external_clock_active;
  endproperty
  a_ext: assert property (p_ext) else $error("pin not ORed in");
  // Every new code on the DAC is announced by the load pulse in the same cycle
  property p_load;
    $changed(dac_code) |-> dac_load;
  endproperty
  a_load: assert property (p_load) else $error("code changed without load");
  c_ext: cover property (hold_strobe && external_clock_active);
  c_pause: cover property (hold_strobe && sequencer_paused);
  c_load: cover property ($fell(reset_load_active));
endmodule
bind dsq_top dsq_assertions u_chk (.sys_clk, .resetn, .cs_n, .clock_source_pin, .dac_code, .dac_load,
  .hold_strobe, .hold_channel, .oscillator_enable, .reset_load_active, .sequencer_paused,
  .update_mode_bit, .clock_source_bit, .external_clock_active);

// file: verification/dsq_host.sv
// Serial host model that frames 24-bit words on chip select
`timescale 1ns/100ps
module dsq_host (
  output logic serial_clk,
  output logic cs_n,
  output logic serial_data
);
  initial begin
    serial_clk  = 1'b0;
    cs_n        = 1'b1;
    serial_data = 1'b1;
  end
  // Link clock runs only inside frames, 80 ns period
  task automatic send_word(input logic [23:0] w, input logic more);
    int i;
    #13;
    cs_n = 1'b0;
    for (i = 23; i >= 0; i--) begin
      serial_data = w[i];
      #40 serial_clk = 1'b1;
      #40 serial_clk = 1'b0;
    end
    if (!more) begin
      #40 cs_n = 1'b1;
    end
    // Released line must not keep showing the last bit
    serial_data = ~serial_data;
  endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the DAC refresh sequencer
`timescale 1ns/100ps
module testbench;
  typedef struct {
    logic [15:0] code;
    logic [4:0]  ch;
    logic        mode;
    logic        clk;
    logic        pin;
    logic        more;
    int          wait_c;
  } dsq_row_t;
  // Code, channel, mode bit, clock bit, immediate pin, frame goes on, settle cycles
  dsq_row_t rows [7] = '{
    '{16'h1234, 5'h00, 1'b1, 1'b0, 1'b0, 1'b0, 2250},
    '{16'hABCD, 5'h14, 1'b0, 1'b0, 1'b1, 1'b0, 2250},
    '{16'h8001, 5'h1F, 1'b1, 1'b0, 1'b0, 1'b0, 2250},
    '{16'h0F0F, 5'h05, 1'b0, 1'b1, 1'b0, 1'b1, 0},
    '{16'hF0F0, 5'h06, 1'b0, 1'b1, 1'b0, 1'b1, 0},
    '{16'h5A5A, 5'h1E, 1'b0, 1'b1, 1'b0, 1'b0, 3500},
    '{16'h0707, 5'h07, 1'b1, 1'b0, 1'b0, 1'b0, 2250}
  };
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        immediate_pin = 1'b0;
  logic        clock_source_pin = 1'b0;
  logic        external_sequencer_clock = 1'b0;
  logic        reset_pin_n = 1'b1;
  logic        ext_run = 1'b1;
  logic        serial_clk;
  logic        cs_n;
  logic        serial_data;
  logic [15:0] dac_code;
  logic        dac_load;
  logic        hold_strobe;
  logic [4:0]  hold_channel;
  logic        oscillator_enable;
  logic        reset_load_active;
  logic        sequencer_paused;
  logic        update_mode_bit;
  logic        clock_source_bit;
  logic        external_clock_active;
  logic [15:0] out_val [32];
  logic [15:0] dac_prev;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  int          strobes = 0;
  int          frame_strobes = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #5 sys_clk = ~sys_clk;
  // 160 ns period gives 64 system cycles per external step
  always #80 if (ext_run) external_sequencer_clock = ~external_sequencer_clock;
  dsq_host host (.serial_clk, .cs_n, .serial_data);
  dsq_top dut (.sys_clk, .resetn, .serial_clk, .cs_n, .serial_data, .immediate_pin,
    .clock_source_pin, .external_sequencer_clock, .reset_pin_n, .dac_code, .dac_load,
    .hold_strobe, .hold_channel, .oscillator_enable, .reset_load_active, .sequencer_paused,
    .update_mode_bit, .clock_source_bit, .external_clock_active);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // A channel holds the code the DAC showed just before its strobe
  always @(posedge sys_clk) begin
    cycles++;
    dac_prev <= dac_code;
    if (hold_strobe === 1'b1) begin
      out_val[hold_channel] <= dac_prev;
      strobes++;
      if (cs_n === 1'b0) frame_strobes++;
    end
    if (cycles == 95000) begin
      failures++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int j;
    int k;
    int n;
    cyc(3);
    check(dac_code, 16'h4F2C);
    check(16'(reset_load_active), 16'h0001);
    check(16'(oscillator_enable), 16'h0001);
    resetn = 1'b1;
    for (n = 0; n < 33000 && reset_load_active !== 1'b0; n++) cyc(1);
    cyc(2);
    check(16'(strobes), 16'h0020);
    for (i = 0; i < 32; i++) check(out_val[i], 16'h4F2C);
    j = 0;
    for (i = 0; i < 7; i++) begin
      immediate_pin = rows[i].pin;
      host.send_word({rows[i].code, rows[i].ch, rows[i].mode, rows[i].clk, 1'b0},
        rows[i].more);
      if (!rows[i].more) begin
        cyc(rows[i].wait_c);
        for (k = j; k <= i; k++) check(out_val[rows[k].ch], rows[k].code);
        check(16'(update_mode_bit), 16'(rows[i].mode));
        check(16'(clock_source_bit), 16'(rows[i].clk));
        check(16'(external_clock_active), 16'(rows[i].clk));
        check(16'(frame_strobes <= 2), 16'h0001);
        frame_strobes = 0;
        j = i + 1;
      end
    end
    clock_source_pin = 1'b1;
    cyc(200);
    check(16'(oscillator_enable), 16'h0000);
    check(16'(external_clock_active), 16'h0001);
    k = strobes;
    while (strobes == k) cyc(1);
    k = strobes;
    n = 0;
    while (strobes == k) begin
      cyc(1);
      n++;
    end
    check(16'(n), 16'h0040);
    ext_run = 1'b0;
    cyc(20);
    k = strobes;
    cyc(500);
    check(16'(strobes - k), 16'h0000);
    // Load must run on the internal clock although the external one is stopped
    reset_pin_n = 1'b0;
    cyc(10);
    reset_pin_n = 1'b1;
    cyc(10);
    check(16'(reset_load_active), 16'h0001);
    k = strobes;
    host.send_word({16'h1111, 5'h09, 1'b1, 1'b1, 1'b0}, 1'b0);
    for (n = 0; n < 33500 && reset_load_active !== 1'b0; n++) cyc(1);
    cyc(2);
    check(16'(strobes - k), 16'h0020);
    check(out_val[7], 16'h4F2C);
    check(16'(update_mode_bit), 16'h0000);
    ext_run = 1'b1;
    cyc(2300);
    check(out_val[9], 16'h4F2C);
    close_out();
  end
endmodule
